// ==== hw/host_port_device.sv ====
// Device end of the buffered host port
// Contract
// [RULE1] Polarity strap sets read/write sense
// [RULE2] No-wait strap selects handshake style
// [RULE3] Acknowledge used as wait only nonzero-wait
// [RULE4] Gate high passes, low holds latches
// [RULE5] Transparent mode latches always pass
// [RULE6] Byte half select only in 8-bit
// [RULE7] Grant on select, strobe low, RAM free
// [RULE8] Host may release select after grant
// [RULE9] Memory/register high memory, low registers
// [RULE10] Capture memreg/direction at next falling edge
// [RULE11] Acknowledge falls three clocks after grant
// [RULE12] Acknowledge changes after rising clock edge
// [RULE13] Read data valid before acknowledge
// [RULE14] Read data driven after rising edge
// [RULE15] No timeout while strobe held low
// [RULE16] Strobe rise ends grant and acknowledge
// [RULE17] Hold data then tri-state after strobe
// [RULE18] Strobe high until acknowledge returns
// [RULE19] RAM address 13:0, registers 4:0
// [RULE20] Read source chosen by captured memreg
// [RULE21] Zero-wait completes without waiting acknowledge
module host_port_device
    import host_port_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          srst,
    host_port_if.device        port,
    input  wire logic          polarity_strap,
    input  wire logic          no_wait_strap,
    input  wire logic          buffered_mode,
    input  wire logic          width16,
    input  wire logic          byte_high,
    input  wire logic          engine_ram_busy,
    output logic               wr_strobe,
    output host_port_pkg::addr_t wr_addr,
    output logic               wr_mem,
    output host_port_pkg::data_t wr_data
);
    import host_port_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_ACK, HOLD} state_t;

    state_t          state_q, state_d;
    logic [TIMER_W-1:0] timer_q;
    addr_t           address_hold_gate_q;
    logic            sel_lat_q, mem_lat_q;
    logic            mem_cap_q, rw_cap_q;
    logic            cap_valid_q;
    logic            grant_q, ack_q, oe_q;
    data_t           rdata_q;
    logic            wrote_q;
    logic            strap_nzw_q;
    data_t           ram [RAM_DEPTH];
    data_t           regs [REG_DEPTH];

    ////////////////////////////////////////////////////////////////
    // Address input latches
    wire latch_open = !buffered_mode || port.address_hold_gate;           // [RULE5]
    wire addr_t addr_int = latch_open ? port.addr : address_hold_gate_q;           // [RULE4]
    wire sel_int = latch_open ? port.select_n : sel_lat_q;
    wire mem_int = latch_open ? port.mem_reg : mem_lat_q;
    wire mem_eff = cap_valid_q ? mem_cap_q : mem_int;                     // [RULE10]
    wire rw_raw = cap_valid_q ? rw_cap_q : port.rd_wr;
    wire is_read = (rw_raw == polarity_strap);                            // [RULE1]
    wire is_mem = (mem_eff == MEM_SEL_MEMORY);                            // [RULE9]
    wire [RAM_AW-1:0] ram_idx = addr_int[RAM_AW-1:0];                     // [RULE19]
    wire [REG_AW-1:0] reg_idx = addr_int[REG_AW-1:0];
    wire request = !sel_int && !port.host_strobe_n && !engine_ram_busy;   // [RULE7]
    wire data_t rd_word = is_mem ? ram[ram_idx] : regs[reg_idx];          // [RULE20]
    wire data_t rd_byte = byte_high ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};
    wire data_t rd_sel = width16 ? rd_word : rd_byte;                     // [RULE6]
    wire nonzero_wait = (strap_nzw_q == STRAP_NONZERO_WAIT);              // [RULE2]

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            address_hold_gate_q <= ADDR_RESET;
            sel_lat_q  <= 1'b1;
            mem_lat_q  <= 1'b0;
        end
        else if (latch_open)
        begin
            address_hold_gate_q <= port.addr;
            sel_lat_q  <= port.select_n;
            mem_lat_q  <= port.mem_reg;
        end
    end

    // Strap caught while in reset
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            strap_nzw_q <= no_wait_strap;
    end

    ////////////////////////////////////////////////////////////////
    // Capture of memreg and direction on the falling edge after grant
    always_ff @(negedge clk_sys)
    begin
        if (srst || !grant_q)
            cap_valid_q <= 1'b0;
        else if (!cap_valid_q)
        begin
            cap_valid_q <= 1'b1;                                          // [RULE10]
            mem_cap_q   <= mem_int;
            rw_cap_q    <= port.rd_wr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Transfer sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            IDLE:     if (request) state_d = WAIT_ACK;
            WAIT_ACK: if (port.host_strobe_n) state_d = IDLE;             // [RULE16]
                      else if (timer_q == TIMER_LAST) state_d = HOLD;
            HOLD:     if (port.host_strobe_n) state_d = IDLE;             // [RULE15]
            default:  state_d = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_q <= IDLE;
            timer_q <= '0;
            grant_q <= 1'b0;
            ack_q   <= 1'b0;
            oe_q    <= 1'b0;
            rdata_q <= DATA_RESET;
            wrote_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            grant_q <= (state_d != IDLE);                                 // [RULE7]
            timer_q <= (state_q == WAIT_ACK) ? timer_q + TIMER_ONE : '0;
            ack_q   <= (state_d == HOLD);                                 // [RULE11] [RULE12]
            oe_q    <= (state_d != IDLE) && is_read;                      // [RULE14] [RULE17]
            if (state_d != IDLE && is_read)
                rdata_q <= rd_sel;                                        // [RULE13]
            wrote_q <= (state_q == IDLE) ? 1'b0 : (wrote_q || wr_strobe);
        end
    end

    // Write path; in zero-wait mode the write lands on the rising edge one clock after grant
    assign wr_strobe = (state_q != IDLE) && !wrote_q && cap_valid_q && !is_read
                       && (!nonzero_wait || state_q == HOLD);             // [RULE21]
    assign wr_addr = addr_int;
    assign wr_mem  = is_mem;
    assign wr_data = port.data_from_host;

    always_ff @(posedge clk_sys)
    begin
        if (wr_strobe && is_mem)
            ram[ram_idx] <= port.data_from_host;
        else if (wr_strobe)
            regs[reg_idx] <= port.data_from_host;
    end

    assign port.access_grant_n = !grant_q;
    assign port.transfer_ack_n = !(ack_q && nonzero_wait);                // [RULE3]
    assign port.data_from_dev  = rdata_q;
    assign port.data_dev_oe    = oe_q;
endmodule

// ==== shared/host_port_pkg.sv ====
// Shared constants and types for the buffered host port
package host_port_pkg;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 16;
    localparam int RAM_AW    = 14;
    localparam int REG_AW    = 5;
    localparam int RAM_DEPTH = 1 << RAM_AW;
    localparam int REG_DEPTH = 1 << REG_AW;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACK_DELAY_CYC = 3;
    localparam int TIMER_W = 2;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 2'h1;
    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(ACK_DELAY_CYC - 1);
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic MEM_SEL_MEMORY = 1'b1;
    localparam logic STRAP_NONZERO_WAIT = 1'b1;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;
endpackage

// ==== shared/host_port_if.sv ====
// Pin-level carrier between host and device
interface host_port_if;
    import host_port_pkg::*;
    logic  select_n;
    logic  host_strobe_n;
    logic  rd_wr;
    logic  mem_reg;
    logic  address_hold_gate;
    addr_t addr;
    data_t data_from_host;
    logic  data_host_oe;
    data_t data_from_dev;
    logic  data_dev_oe;
    logic  access_grant_n;
    logic  transfer_ack_n;
    modport device (input select_n, host_strobe_n, rd_wr, mem_reg, address_hold_gate, addr,
                    data_from_host, data_host_oe,
                    output data_from_dev, data_dev_oe, access_grant_n, transfer_ack_n);
    modport host (output select_n, host_strobe_n, rd_wr, mem_reg, address_hold_gate, addr,
                  data_from_host, data_host_oe,
                  input data_from_dev, data_dev_oe, access_grant_n, transfer_ack_n);
endinterface

// ==== hw/host_port_host.sv ====
// Host end of the buffered host port
module host_port_host
    import host_port_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            srst,
    host_port_if.host            port,
    input  wire logic            polarity_strap,
    input  wire logic            no_wait_strap,
    input  wire logic            req_valid,
    output logic                 req_ready,
    input  wire logic            req_read,
    input  wire logic            req_mem,
    input  wire host_port_pkg::addr_t req_addr,
    input  wire host_port_pkg::data_t req_wdata,
    output logic                 done,
    output host_port_pkg::data_t rdata
);
    import host_port_pkg::*;

    typedef enum logic [1:0] {IDLE, GRANT, ACKED, RECOVER} state_t;

    state_t state_q, state_d;
    addr_t  addr_q;
    data_t  wdata_q, rdata_q;
    logic   read_q, mem_q, done_q;

    wire nonzero_wait = (no_wait_strap == STRAP_NONZERO_WAIT);
    wire finished = nonzero_wait ? !port.transfer_ack_n : !port.access_grant_n; // [RULE3]

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            IDLE:    if (req_valid) state_d = GRANT;
            GRANT:   if (finished) state_d = ACKED;
            ACKED:   state_d = RECOVER;
            RECOVER: if (port.transfer_ack_n && port.access_grant_n) state_d = IDLE; // [RULE18]
            default: state_d = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_q <= IDLE;
            addr_q  <= ADDR_RESET;
            wdata_q <= DATA_RESET;
            rdata_q <= DATA_RESET;
            read_q  <= 1'b1;
            mem_q   <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_q  <= (state_q == ACKED);
            if (state_q == IDLE && req_valid)
            begin
                addr_q  <= req_addr;
                wdata_q <= req_wdata;
                read_q  <= req_read;
                mem_q   <= req_mem;
            end
            if (state_q == GRANT && finished && read_q)
                rdata_q <= port.data_from_dev;
        end
    end

    // Select and strobe tied together for the whole cycle
    wire active = (state_q == GRANT) || (state_q == ACKED);               // [RULE8]
    // Address lines shared with other traffic: valid only while gate open
    wire gate_open = (state_q == GRANT) && port.access_grant_n;

    assign req_ready              = (state_q == IDLE);
    assign port.select_n          = !active;
    assign port.host_strobe_n     = !active;
    assign port.rd_wr             = read_q ? polarity_strap : !polarity_strap; // [RULE1]
    assign port.mem_reg           = mem_q;                                // [RULE9]
    assign port.address_hold_gate = gate_open;
    assign port.addr              = gate_open ? addr_q : ~addr_q;
    assign port.data_from_host    = wdata_q;
    assign port.data_host_oe      = active && !read_q;
    assign done                   = done_q;
    assign rdata                  = rdata_q;
endmodule

// ==== tb/host_port_chk.sv ====
// Handshake checker for the host port
module host_port_chk
    import host_port_pkg::*;
(
    input wire logic  clk_sys,
    input wire logic  srst,
    input wire logic  select_n,
    input wire logic  host_strobe_n,
    input wire logic  access_grant_n,
    input wire logic  transfer_ack_n,
    input wire logic  data_dev_oe,
    input wire data_t data_from_dev
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_grant_cause;
        $fell(access_grant_n) |-> !$past(select_n) && !$past(host_strobe_n);
    endproperty
    a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
    property p_ack_delay;
        $fell(transfer_ack_n) |-> !$past(access_grant_n, 3) && $past(access_grant_n, 4);
    endproperty
    a_ack_delay: assert property (p_ack_delay) else $error("ack not three cycles after grant");
    property p_ack_in_grant;
        !transfer_ack_n |-> !access_grant_n;
    endproperty
    a_ack_in_grant: assert property (p_ack_in_grant) else $error("ack outside grant");
    property p_release;
        $rose(host_strobe_n) && !access_grant_n |=> access_grant_n && transfer_ack_n && !data_dev_oe;
    endproperty
    a_release: assert property (p_release) else $error("cycle not ended on strobe rise");
    property p_hold_open;
        !host_strobe_n && !access_grant_n |=> !access_grant_n && $stable(transfer_ack_n) || !transfer_ack_n;
    endproperty
    a_hold_open: assert property (p_hold_open) else $error("cycle closed while strobe low");
    property p_data_before_ack;
        $fell(transfer_ack_n) && data_dev_oe |-> $past(data_dev_oe) && $stable(data_from_dev);
    endproperty
    a_data_before_ack: assert property (p_data_before_ack) else $error("data late for ack");
    property p_quiet;
        host_strobe_n && $past(host_strobe_n) |-> access_grant_n && transfer_ack_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("grant while strobe high");
    property p_oe_in_grant;
        data_dev_oe |-> !access_grant_n;
    endproperty
    a_oe_in_grant: assert property (p_oe_in_grant) else $error("data driven outside grant");
    property p_strobe_waits;
        $fell(host_strobe_n) |-> access_grant_n && transfer_ack_n;
    endproperty
    a_strobe_waits: assert property (p_strobe_waits) else $error("strobe before ack release");
    c_ack: cover property ($fell(transfer_ack_n));
    c_read: cover property ($fell(transfer_ack_n) && data_dev_oe);
    c_end: cover property ($rose(access_grant_n));
endmodule

// ==== tb/tb.sv ====
// Testbench joining host and device ends of the port
module tb;
    import host_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic  clk_sys, srst, pol, nzw, buf_m, w16, bh, busy, rv, rr, rm, wrs, wm, rdy, dn, ack_seen, rw_seen, wm_seen;
    addr_t ra, wa, wra;
    data_t rw, wd, wrd, rdat, got;
    int    failures = 0;
    int    checks = 0;
    int    cyc = 0;
    host_port_if pb ();
    host_port_device host_port_device_inst (.clk_sys(clk_sys), .srst(srst), .port(pb), .polarity_strap(pol),
        .no_wait_strap(nzw), .buffered_mode(buf_m), .width16(w16), .byte_high(bh), .engine_ram_busy(busy),
        .wr_strobe(wrs), .wr_addr(wra), .wr_mem(wm), .wr_data(wrd));
    host_port_host host_port_host_inst (.clk_sys(clk_sys), .srst(srst), .port(pb), .polarity_strap(pol),
        .no_wait_strap(nzw), .req_valid(rv), .req_ready(rdy), .req_read(rr), .req_mem(rm), .req_addr(ra),
        .req_wdata(rw), .done(dn), .rdata(rdat));
    host_port_chk host_port_chk_inst (.clk_sys(clk_sys), .srst(srst), .select_n(pb.select_n),
        .host_strobe_n(pb.host_strobe_n), .access_grant_n(pb.access_grant_n), .transfer_ack_n(pb.transfer_ack_n),
        .data_dev_oe(pb.data_dev_oe), .data_from_dev(pb.data_from_dev));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (wrs === 1'b1)
        begin
            wa <= wra;
            wd <= wrd;
            wm_seen <= wm;
        end
        if (pb.transfer_ack_n === 1'b0)
            ack_seen <= 1'b1;
        if (pb.access_grant_n === 1'b0)
            rw_seen <= pb.rd_wr;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input string what, input data_t exp, input data_t seen);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset();
        srst = 1;
        repeat (20) @(posedge clk_sys);
        #1 srst = 0;
    endtask
    task automatic xfer(input logic rd, input logic mem, input addr_t a, input data_t w);
        int n;
        n = 0;
        rv = 1;
        rr = rd;
        rm = mem;
        ra = a;
        rw = w;
        while (rdy !== 1'b1)
        begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1 rv = 0;
        while (dn !== 1'b1 && n < 200)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk("done", 16'h0001, 16'(n < 200));
        got = rdat;
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        {pol, nzw, buf_m, w16, bh, busy, rv, rr, rm, ack_seen} = 10'h3C0;
        ra = 16'h0000;
        rw = 16'h0000;
        srst = 1'h1;
        do_reset();
        xfer(1'h0, 1'h1, 16'h3FFF, 16'hA5A5);
        chk("wr_data", 16'hA5A5, wd);
        chk("wr_mem", 16'h0001, 16'(wm_seen));
        chk("wr_addr", 16'h3FFF, wa & 16'h3FFF);
        xfer(1'h0, 1'h0, 16'h0023, 16'h1234);
        chk("held address", 16'h0023, wa);
        chk("wr_mem", 16'h0000, 16'(wm_seen));
        xfer(1'h1, 1'h1, 16'hFFFF, 16'h0000);
        chk("ram read", 16'hA5A5, got);
        chk("read sense", 16'h0001, 16'(rw_seen));
        xfer(1'h1, 1'h0, 16'h0003, 16'h0000);
        chk("reg read", 16'h1234, got);
        chk("ack used", 16'h0001, 16'(ack_seen));
        busy = 1'h1;
        fork
            xfer(1'h1, 1'h1, 16'h3FFF, 16'h0000);
            begin
                repeat (10) @(posedge clk_sys);
                #1;
                chk("grant held off", 16'h0001, 16'(pb.access_grant_n));
                busy = 1'h0;
            end
        join
        chk("deferred read", 16'hA5A5, got);
        pol = 1'h0;
        xfer(1'h0, 1'h1, 16'h0100, 16'hBEEF);
        xfer(1'h1, 1'h1, 16'h0100, 16'h0000);
        chk("inverted sense", 16'hBEEF, got);
        chk("read sense", 16'h0000, 16'(rw_seen));
        w16 = 1'h0;
        bh = 1'h1;
        xfer(1'h1, 1'h1, 16'h0100, 16'h0000);
        chk("high byte", 16'h00BE, got & 16'h00FF);
        bh = 1'h0;
        xfer(1'h1, 1'h1, 16'h0100, 16'h0000);
        chk("low byte", 16'h00EF, got & 16'h00FF);
        w16 = 1'h1;
        bh = 1'h1;
        xfer(1'h1, 1'h1, 16'h0100, 16'h0000);
        chk("byte ignored", 16'hBEEF, got);
        // Transparent latches follow the live lines after the gate closes
        buf_m = 1'h0;
        xfer(1'h1, 1'h1, 16'hFEFF, 16'h0000);
        chk("transparent", 16'hBEEF, got);
        buf_m = 1'h1;
        nzw = 1'h0;
        do_reset();
        ack_seen = 1'h0;
        xfer(1'h0, 1'h0, 16'h0007, 16'h5A0F);
        xfer(1'h1, 1'h0, 16'h0007, 16'h0000);
        chk("zero wait read", 16'h5A0F, got);
        chk("no ack", 16'h0000, 16'(ack_seen));
        final_report();
    end
endmodule
